// >>> verilog/sacp_pkg.sv
// Purpose: constants for the converter serial port and feature configuration register
// Assumes: core clock of 40 MHz; link clock is the host serial clock
// Notes: rule summary below
// What this block does
// - three-wire uses start, clock, output; four-wire adds serial input
// - optional busy indication marks when a result becomes available
// - several converters chain their results over one serial bus
// - turbo bit set only removes busy indication; readback window unchanged
// - status enable appends status bits after the result data
// - power-up output low unless start and serial input both high
// - one eight-bit configuration register with enables and overvoltage flag
// - every register access is one sixteen-bit serial frame
// - bit 4 enables status bits, resets to zero
// - bit 3 enables input range compression, resets to zero
// - bit 2 enables low-kickback input mode, resets to zero
// - bit 1 enables turbo timing, resets to zero
// - bit 0 active-low overvoltage flag, sticky, cleared by read after event
// - writes never change read-only bits; reserved bits 7 to 5 read zero
// - frame starts with start low; command 0, read/write, then 010100
// - input taken on rising, output shifted on falling, released at start high
// - data byte msb first; fields update only after whole byte
// - six status bits msb first after result lsb, then release, or chained serial input when daisy chain is set
package sacp_pkg;
	localparam int          CFG_W          = 8;
	localparam int          RESULT_W       = 16;
	localparam int          STATUS_W       = 6;
	localparam int          CMD_W          = 8;
	localparam int          FRAME_BITS     = 16;
	localparam int          CNT_W          = 6;
	localparam int          BIT_OV_N       = 0;
	localparam int          BIT_TURBO      = 1;
	localparam int          BIT_LOW_KICK   = 2;
	localparam int          BIT_SPAN       = 3;
	localparam int          BIT_STATUS_EN  = 4;
	localparam logic [7:0]  CFG_RESET      = 8'h01;
	localparam logic [7:0]  CFG_RW_MASK    = 8'h1e;
	localparam logic [5:0]  CMD_PATTERN    = 6'h14;
	localparam logic        CMD_READ       = 1'h1;
	localparam logic [5:0]  STREAM_PLAIN   = 6'h10;
	localparam logic [5:0]  STREAM_STATUS  = 6'h16;
	localparam logic [5:0]  CNT_MAX        = 6'h3f;
	localparam int          CORE_PERIOD_NS = 25;
	localparam int          CONV_TIME_NS   = 290;
	localparam int          CONV_CYCLES    = (CONV_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int          CONV_CNT_W     = 5;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_CONV    = 3'b010,
		ST_PUBLISH = 3'b100
	} sacp_state_t;
endpackage : sacp_pkg

// >>> verilog/sacp_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: inputs are levels, quasi-static per bit
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module sacp_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// data
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : sacp_sync2
`default_nettype wire

// >>> verilog/sacp_core.sv
// Purpose: serial host port and feature configuration register of a 16-bit converter
// Assumes: RESULT_I is valid in the core domain when the conversion ends
// Notes: serial clock is a domain of its own; start line frames it asynchronously
`timescale 1ns/1ps
`default_nettype none
module sacp_core
	import sacp_pkg::*;
(
	// core clock and reset
	input  wire logic                          CORE_CLK_I,
	input  wire logic                          RST_N_I,
	// serial link
	input  wire logic                          SCK_I,
	input  wire logic                          CONV_START_I,
	input  wire logic                          SERIAL_INPUT_I,
	output var  logic                          SERIAL_OUTPUT_O,
	output var  logic                          SERIAL_OUTPUT_OE_O,
	// converter side
	input  wire logic [sacp_pkg::RESULT_W-1:0] RESULT_I,
	input  wire logic                          OV_EVENT_I,
	input  wire logic                          BUSY_EN_I,
	input  wire logic                          DAISY_CHAIN_I,
	output var  logic                          BUSY_O,
	output var  logic                          CONVERTING_O,
	// feature controls
	output var  logic                          STATUS_EN_O,
	output var  logic                          SPAN_COMPRESS_O,
	output var  logic                          LOW_KICKBACK_O,
	output var  logic                          TURBO_O,
	output var  logic                          OV_FLAG_N_O
);
	import sacp_pkg::*;

	// core domain
	logic [3:0]               pin_s;
	logic                     cnv_s;
	logic                     sdi_s;
	logic                     ov_s;
	logic                     busy_en_s;
	logic                     cnv_d;
	logic                     pwr_hold;
	sacp_state_t              state;
	logic [CONV_CNT_W-1:0]    conv_cnt;
	logic [RESULT_W-1:0]      result_word;
	logic [CFG_W-1:0]         cfg;
	logic [2:0]               link_s;
	logic                     wr_tog_d;
	logic                     rd_tog_d;
	logic                     wr_evt;
	logic                     rd_evt;
	logic                     done_s;
	logic                     oe;
	// link domain
	logic                     frame_rst_n;
	logic [CNT_W-1:0]         bit_n;
	logic [CMD_W-2:0]         cmd_sh;
	logic [CMD_W-2:0]         data_sh;
	logic                     is_read;
	logic                     is_write;
	logic [CFG_W-1:0]         wr_data;
	logic                     wr_tog;
	logic                     rd_tog;
	logic [RESULT_W-1:0]      snap_res;
	logic [CFG_W-1:0]         snap_cfg;
	logic [STATUS_W-1:0]      snap_st;
	logic [5:0]               stream_len;
	logic                     chain_q;
	logic                     serial_output;
	logic                     done;
	logic [CFG_W-1:0]         cfg_l;
	logic                     chain_l;
	logic [CNT_W-1:0]         idx;

	function automatic logic cmd_match(input logic [CMD_W-1:0] c);
		return (c[7] == 1'b0) && (c[5:0] == CMD_PATTERN);
	endfunction : cmd_match

	function automatic logic stream_bit(input logic [5:0] i, input logic [RESULT_W-1:0] res,
	                                    input logic [CFG_W-1:0] c, input logic [STATUS_W-1:0] st,
	                                    input logic rd);
		logic b;
		b = 1'b0;
		if (i < STREAM_PLAIN) begin
			if (rd && i >= 6'd8)
				b = c[3'(6'd15 - i)];
			else
				b = res[4'(6'd15 - i)];
		end else if (i < STREAM_STATUS) begin
			b = st[3'(6'd21 - i)];
		end
		return b;
	endfunction : stream_bit

	// ---------------- core domain ----------------
	// start and input enter inverted so reset reads them at their idle high level
	sacp_sync2 #(.W(4)) u_pin_sync (
		.clk_i   (CORE_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({~CONV_START_I, ~SERIAL_INPUT_I, OV_EVENT_I, BUSY_EN_I}),
		.q_o     (pin_s)
	);
	assign cnv_s     = !pin_s[3];
	assign sdi_s     = !pin_s[2];
	assign ov_s      = pin_s[1];
	assign busy_en_s = pin_s[0];

	sacp_sync2 #(.W(3)) u_link_sync (
		.clk_i   (CORE_CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({wr_tog, rd_tog, done}),
		.q_o     (link_s)
	);
	assign done_s = link_s[0];
	assign wr_evt = link_s[2] ^ wr_tog_d;
	assign rd_evt = link_s[1] ^ rd_tog_d;

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cnv_d    <= 1'b1;
			wr_tog_d <= 1'b0;
			rd_tog_d <= 1'b0;
		end else begin
			cnv_d    <= cnv_s;
			wr_tog_d <= link_s[2];
			rd_tog_d <= link_s[1];
		end
	end

	// power-up output state holds until the first frame opens
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			pwr_hold <= 1'b1;
		else if (cnv_d && !cnv_s)
			pwr_hold <= 1'b0;
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I)
			oe <= 1'b0;
		else if (pwr_hold)
			oe <= !(cnv_s && sdi_s);
		else
			oe <= !cnv_s && !done_s;
	end
	assign SERIAL_OUTPUT_OE_O = oe;

	// conversion sequencer: start on start-line rise
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state       <= ST_IDLE;
			conv_cnt    <= '0;
			result_word <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					conv_cnt <= '0;
					if (cnv_s && !cnv_d)
						state <= ST_CONV;
				end
				ST_CONV: begin
					conv_cnt <= conv_cnt + 5'd1;
					if (conv_cnt == CONV_CNT_W'(CONV_CYCLES - 1))
						state <= ST_PUBLISH;
				end
				ST_PUBLISH: begin
					// word changes only outside a frame; old word stays readable meanwhile
					conv_cnt <= '0;
					if (cnv_s) begin
						result_word <= RESULT_I;
						// a start edge landing here launches the next conversion at once
						state       <= cnv_d ? ST_IDLE : ST_CONV;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			BUSY_O       <= 1'b0;
			CONVERTING_O <= 1'b0;
		end else begin
			BUSY_O       <= busy_en_s && !cfg[BIT_TURBO] && (state != ST_IDLE);
			CONVERTING_O <= (state == ST_CONV);
		end
	end

	// configuration register; overvoltage event beats the read that would clear it
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cfg <= CFG_RESET;
		end else begin
			if (wr_evt)
				cfg[CFG_W-1:1] <= wr_data[CFG_W-1:1] & CFG_RW_MASK[CFG_W-1:1];
			if (ov_s)
				cfg[BIT_OV_N] <= 1'b0;
			else if (rd_evt)
				cfg[BIT_OV_N] <= 1'b1;
		end
	end

	assign STATUS_EN_O     = cfg[BIT_STATUS_EN];
	assign SPAN_COMPRESS_O = cfg[BIT_SPAN];
	assign LOW_KICKBACK_O  = cfg[BIT_LOW_KICK];
	assign TURBO_O         = cfg[BIT_TURBO];
	assign OV_FLAG_N_O     = cfg[BIT_OV_N];

	// ---------------- link domain ----------------
	assign frame_rst_n = RST_N_I && !CONV_START_I;

	sacp_sync2 #(.W(9)) u_cfg_sync (
		.clk_i   (SCK_I),
		.rst_n_i (RST_N_I),
		.d_i     ({DAISY_CHAIN_I, cfg}),
		.q_o     ({chain_l, cfg_l})
	);

	// capture side, rising edges
	always_ff @(posedge SCK_I or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_n    <= '0;
			cmd_sh   <= '0;
			data_sh  <= '0;
			is_read  <= 1'b0;
			is_write <= 1'b0;
			chain_q  <= 1'b0;
			snap_res <= '0;
			snap_cfg <= '0;
			snap_st  <= '0;
			stream_len <= STREAM_PLAIN;
		end else begin
			if (bit_n != CNT_MAX)
				bit_n <= bit_n + 6'd1;
			chain_q <= SERIAL_INPUT_I;
			if (bit_n == 6'd0)
				snap_res   <= result_word;
			// config sync needs two link edges after the idle gap, so read it at the third
			if (bit_n == 6'd2) begin
				snap_cfg   <= cfg_l;
				snap_st    <= {cfg_l[BIT_OV_N], cfg_l[BIT_STATUS_EN], cfg_l[BIT_SPAN],
				               cfg_l[BIT_LOW_KICK], cfg_l[BIT_TURBO], 1'b0};
				stream_len <= cfg_l[BIT_STATUS_EN] ? STREAM_STATUS : STREAM_PLAIN;
			end
			if (bit_n < 6'd7)
				cmd_sh <= {cmd_sh[CMD_W-3:0], SERIAL_INPUT_I};
			if (bit_n == 6'd7 && cmd_match({cmd_sh, SERIAL_INPUT_I})) begin
				is_read  <= (cmd_sh[5] == CMD_READ);
				is_write <= (cmd_sh[5] != CMD_READ);
			end
			if (bit_n >= 6'd8 && bit_n < 6'd15)
				data_sh <= {data_sh[CMD_W-3:0], SERIAL_INPUT_I};
		end
	end

	// write data and events survive the frame end for the core to pick up
	always_ff @(posedge SCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_data <= CFG_RESET;
			wr_tog  <= 1'b0;
			rd_tog  <= 1'b0;
		end else if (!CONV_START_I) begin
			if (bit_n == 6'd15 && is_write) begin
				wr_data <= {data_sh, SERIAL_INPUT_I};
				wr_tog  <= !wr_tog;
			end
			if (bit_n == 6'd7 && cmd_match({cmd_sh, SERIAL_INPUT_I}) && cmd_sh[5] == CMD_READ)
				rd_tog <= !rd_tog;
		end
	end

	// drive side, falling edges; bit n-1 after n rising edges
	assign idx = bit_n - 6'd1;

	always_ff @(negedge SCK_I or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			serial_output  <= 1'b0;
			done <= 1'b0;
		end else if (bit_n != 6'd0) begin
			if (idx < stream_len)
				serial_output <= stream_bit(idx, snap_res, snap_cfg, snap_st, is_read);
			else if (chain_l)
				serial_output <= chain_q;
			else begin
				serial_output  <= 1'b0;
				done <= 1'b1;
			end
		end
	end
	assign SERIAL_OUTPUT_O = serial_output;

	// ---------------- checks ----------------
	localparam int CONV_CYC_A = CONV_CYCLES;

	conv_length_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		$rose(state == ST_CONV) |-> ##CONV_CYC_A (state == ST_PUBLISH))
		else $error("conversion length wrong");
	busy_turbo_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		$past(cfg[BIT_TURBO]) |-> !BUSY_O)
		else $error("busy shown in turbo");
	busy_show_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(busy_en_s && !cfg[BIT_TURBO] && state == ST_CONV) |=> BUSY_O)
		else $error("busy missing during conversion");
	ov_set_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		ov_s |=> !cfg[BIT_OV_N])
		else $error("overvoltage not flagged");
	ov_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(!cfg[BIT_OV_N] && !rd_evt) |=> !cfg[BIT_OV_N])
		else $error("overvoltage flag cleared without read");
	write_mask_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		wr_evt |=> (cfg[7:5] == 3'h0) && (cfg[4:1] == $past(wr_data[4:1])) && ($stable(cfg[BIT_OV_N]) || $past(ov_s)))
		else $error("write touched wrong bits");
	pwrup_oe_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		pwr_hold |=> (oe == !($past(cnv_s) && $past(sdi_s))))
		else $error("power-up output state wrong");
	frame_release_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(!pwr_hold && cnv_s) |=> !oe)
		else $error("output not released");
	publish_word_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state == ST_PUBLISH && cnv_s) |=> (result_word == $past(RESULT_I))
			&& (state == ($past(cnv_d) ? ST_IDLE : ST_CONV)))
		else $error("result not published");
	write_event_a: assert property (@(posedge SCK_I) disable iff (!frame_rst_n)
		(bit_n == 6'd15 && is_write) |=> (wr_tog != $past(wr_tog)))
		else $error("write frame lost");
	stream_end_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(!pwr_hold && done_s) |=> !oe)
		else $error("output not released after stream");
	read_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(rd_evt && !ov_s) |=> cfg[BIT_OV_N])
		else $error("overvoltage flag not cleared by read");
	busy_idle_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		(state == ST_IDLE) |=> !BUSY_O)
		else $error("busy shown while idle");

	write_seen_c:   cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) wr_evt);
	read_clear_c:   cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		!cfg[BIT_OV_N] ##1 rd_evt ##1 cfg[BIT_OV_N]);
	turbo_conv_c:   cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
		cfg[BIT_TURBO] && state == ST_PUBLISH);
	status_frame_c: cover property (@(negedge SCK_I) disable iff (!frame_rst_n)
		stream_len == STREAM_STATUS && idx == 6'd21);
	chain_frame_c:  cover property (@(negedge SCK_I) disable iff (!frame_rst_n) chain_l && idx == 6'd16);
endmodule : sacp_core
`default_nettype wire

// >>> verification/sacp_host.sv
// Purpose: host model for the converter serial port
// Assumes: link clock runs only inside frames, 6 ns period
// Notes: serial input changes on falling edges, serial output sampled before rising edges
`timescale 1ns/1ps
`default_nettype none
module sacp_host (
	// pacing clock
	input  wire logic        core_clk_i,
	// serial link
	input  wire logic        sdo_i,
	output var  logic        sck_o,
	output var  logic        cnv_o,
	output var  logic        sdi_o,
	// captured stream
	output var  logic [21:0] rx_o,
	output var  logic        rx_valid_o
);
	initial begin
		sck_o      = 1'b0;
		cnv_o      = 1'b1;
		sdi_o      = 1'b1;
		rx_o       = '0;
		rx_valid_o = 1'b0;
	end

	task automatic set_sdi(input logic v);
		@(negedge core_clk_i);
		sdi_o = v;
	endtask : set_sdi

	// start pulse without clocks; its rise launches a conversion
	task automatic conv();
		@(negedge core_clk_i);
		cnv_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
		cnv_o = 1'b1;
		repeat (24) @(negedge core_clk_i);
	endtask : conv

	// 16-bit instruction plus 6 extra bits, one leading clock; 166 MHz is fast enough
	task automatic frame(input logic [21:0] sdi_w);
		logic [21:0] rx;
		rx = '0;
		@(negedge core_clk_i);
		cnv_o = 1'b0;
		sdi_o = sdi_w[21];
		#101.3;
		for (int k = 1; k <= 23; k++) begin
			#3;
			if (k >= 2) begin
				rx[23-k] = sdo_i;
			end
			sck_o = 1'b1;
			#3;
			sck_o = 1'b0;
			if (k < 22) begin
				sdi_o = sdi_w[21-k];
			end
		end
		@(negedge core_clk_i);
		cnv_o = 1'b1;
		rx_o = rx;
		rx_valid_o = 1'b1;
		#1;
		rx_valid_o = 1'b0;
	endtask : frame
endmodule : sacp_host
`default_nettype wire

// >>> verification/tb.sv
// Purpose: self-checking bench for the converter serial port
// Assumes: host model owns start line, serial clock and serial input
// Notes: released output pin reads a toggling pattern
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sacp_pkg::*;
	logic        clk, rst_n, sck, conversion_start, serial_input, serial_output, oe, sdo_float, rx_valid;
	logic        ov_event, busy_en, chain, busy, converting;
	logic        st_en, span, lowkick, turbo, ov_n;
	logic [15:0] result;
	logic [21:0] rx;
	logic [21:0] exp_q[$];
	logic [7:0]  cfg_m;
	wire logic   sdo_pin;
	integer      seed = 32'h6f28;
	int          n_errors = 0;
	int          samples_checked = 0;

	sacp_core dut (
		.CORE_CLK_I(clk), .RST_N_I(rst_n), .SCK_I(sck), .CONV_START_I(conversion_start),
		.SERIAL_INPUT_I(serial_input), .SERIAL_OUTPUT_O(serial_output), .SERIAL_OUTPUT_OE_O(oe),
		.RESULT_I(result), .OV_EVENT_I(ov_event), .BUSY_EN_I(busy_en),
		.DAISY_CHAIN_I(chain), .BUSY_O(busy), .CONVERTING_O(converting),
		.STATUS_EN_O(st_en), .SPAN_COMPRESS_O(span), .LOW_KICKBACK_O(lowkick),
		.TURBO_O(turbo), .OV_FLAG_N_O(ov_n)
	);
	sacp_host hst (
		.core_clk_i(clk), .sdo_i(sdo_pin), .sck_o(sck), .cnv_o(conversion_start),
		.sdi_o(serial_input), .rx_o(rx), .rx_valid_o(rx_valid)
	);
	assign sdo_pin = oe ? serial_output : sdo_float;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) sdo_float <= ~sdo_float;

	task automatic check(input logic [21:0] seen, input logic [21:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// expected stream, first bit in bit 21
	function automatic logic [21:0] stream(logic [15:0] res, logic [21:0] s, logic ch);
		logic [15:0] head;
		logic [5:0]  tail;
		head = (s[21:14] == 8'h54) ? {res[15:8], cfg_m} : res;
		tail = cfg_m[4] ? {cfg_m[0], cfg_m[4:1], 1'b0} : (ch ? s[5:0] : 6'h00);
		return {head, tail};
	endfunction : stream

	task automatic run(input logic [21:0] s);
		logic exp_busy;
		@(negedge clk);
		result = 16'($random(seed));
		busy_en = 1'($random(seed));
		exp_busy = busy_en & ~cfg_m[1];
		fork
			hst.conv();
			begin
				repeat (11) @(negedge clk);
				check(busy, exp_busy);
				check(converting, 1'b1);
			end
		join
		check(busy, 1'b0);
		check(converting, 1'b0);
		exp_q.push_back(stream(result, s, chain));
		hst.frame(s);
		if (s[21:14] == 8'h14) cfg_m[4:1] = s[10:7];
		if (s[21:14] == 8'h54 && !ov_event) cfg_m[0] = 1'b1;
		repeat (8) @(negedge clk);
		check({st_en, span, lowkick, turbo, ov_n}, cfg_m[4:0]);
		check(oe, 1'b0);
	endtask : run

	always @(posedge rx_valid) begin
		check(rx, exp_q.pop_front());
	end

	initial begin
		rst_n = 1'b0;
		ov_event = 1'b0;
		busy_en = 1'b0;
		chain = 1'b0;
		result = 16'h0000;
		sdo_float = 1'b0;
		cfg_m = 8'h01;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check(oe, 1'b0);
		check({st_en, span, lowkick, turbo, ov_n}, 5'h01);
		hst.set_sdi(1'b0);
		repeat (6) @(negedge clk);
		check({oe, serial_output}, 2'b10);
		run({8'h54, 14'h0});
		run({8'h14, 8'hff, 6'h00});
		run({8'h54, 14'h0});
		for (int i = 0; i < 6; i++) begin
			run({(i == 3) ? 8'h34 : 8'h14, 8'($random(seed)), 6'h00});
			run({8'h54, 14'h0});
		end
		// overvoltage flag: sticky while present, cleared by a later read
		run({8'h14, 8'h00, 6'h00});
		ov_event = 1'b1;
		cfg_m[0] = 1'b0;
		repeat (8) @(negedge clk);
		check(ov_n, 1'b0);
		run({8'h54, 14'h0});
		ov_event = 1'b0;
		repeat (8) @(negedge clk);
		run({8'h54, 14'h0});
		run({8'h54, 14'h0});
		// chained readout with a non-register command
		chain = 1'b1;
		for (int i = 0; i < 3; i++) begin
			run({8'hc0, 8'($random(seed)), 6'($random(seed))});
		end
		test_done();
	end

	initial begin
		#200us;
		n_errors++;
		test_done();
	end
endmodule : tb
`default_nettype wire
